// ==== hw/charge_pump_mode_control.sv ====
// Charge pump mode supervisor: mode stepping, soft-start, shutdown, thermal
//
// Operation
// [R1] Start 1x, dropout steps 1.5x then 2x
// [R2] Each advance waits 0.4 ms after dropout
// [R3] Shutdown or camera enable fall forces 1x
// [R4] 1x switches wait for output below supply
// [R5] Boost entry ramps current over 150 us
// [R6] Both enables low 150 us: shutdown
// [R7] Shutdown: all off, weak switch only
// [R8] Overtemperature disables sources and pump
// [R9] Two non-overlapping phases, 800 kHz, 35 ns
// [R10] Enable held low zeroes that output
// [R11] 2x is terminal until reset path
`timescale 1ns/1ps
`default_nettype none
module charge_pump_mode_control
  import pump_ctrl_pkg::*;
#(
  parameter int ADVANCE_CYC  = ADVANCE_DELAY_CYC,
  parameter int RAMP_CYC     = SOFT_START_CYC,
  parameter int SHUTDOWN_CYC_P = SHUTDOWN_CYC
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           main_enable_strobe,
  input  wire logic           cam_enable_strobe,
  input  wire analog_status_t status,
  output pump_drive_t         drive,
  output logic [RAMP_W-1:0]   ramp_level,
  output logic                main_output_on,
  output logic                cam_output_on,
  output logic                shutdown
);

  localparam int AW = $clog2(ADVANCE_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);
  localparam int SW = $clog2(SHUTDOWN_CYC_P + 1);
  localparam int SRC_ALL = 2 + NUM_SOURCES;

  // Three-stage synchroniser; a change counts once stages two and three agree
  function automatic logic agree(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0]             sync_main;
  logic [2:0]             sync_cam;
  logic [2:0]             sync_cmp;
  logic [2:0]             sync_hot;
  logic [NUM_SOURCES-1:0] drop_s1;
  logic [NUM_SOURCES-1:0] drop_s2;
  logic [NUM_SOURCES-1:0] drop_s3;
  logic                   main_en;
  logic                   cam_en;
  logic                   out_le_sup;
  logic                   hot;
  logic                   any_drop;

  // Pins are asynchronous to the controller clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_main <= 3'h0;
      sync_cam  <= 3'h0;
      sync_cmp  <= 3'h0;
      sync_hot  <= 3'h0;
      drop_s1   <= '0;
      drop_s2   <= '0;
      drop_s3   <= '0;
    end else begin
      sync_main <= {sync_main[1:0], main_enable_strobe};
      sync_cam  <= {sync_cam[1:0], cam_enable_strobe};
      sync_cmp  <= {sync_cmp[1:0], status.out_le_supply};
      sync_hot  <= {sync_hot[1:0], status.overtemp};
      drop_s1   <= status.dropout;
      drop_s2   <= drop_s1;
      drop_s3   <= drop_s2;
    end
  end

  // Enable, comparator and thermal levels held between agreements; dropout needs stages two and three set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_en    <= 1'b0;
      cam_en     <= 1'b0;
      out_le_sup <= 1'b0;
      hot        <= 1'b0;
      any_drop   <= 1'b0;
    end else begin
      main_en    <= agree(sync_main, main_en);
      cam_en     <= agree(sync_cam, cam_en);
      out_le_sup <= agree(sync_cmp, out_le_sup);
      hot        <= agree(sync_hot, hot);
      any_drop   <= |(drop_s2 & drop_s3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown detection
  logic [SW-1:0] low_count;
  logic          cam_en_d;
  wire           both_low  = !main_en && !cam_en;
  wire           low_done  = (low_count == SW'(SHUTDOWN_CYC_P));
  wire           cam_fall  = cam_en_d && !cam_en;

  // [R6] Low-time counter; any enable high restarts the wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_count <= SW'(SHUTDOWN_CYC_P);
      cam_en_d  <= 1'b0;
    end else begin
      cam_en_d  <= cam_en;
      if (!both_low) begin
        low_count <= '0;
      end else if (!low_done) begin
        low_count <= low_count + SW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode stepping with advance delay
  pump_mode_t    mode;
  logic [AW-1:0] adv_count;
  logic          adv_pending;
  logic          reset_to_1x;
  wire           adv_done  = adv_pending && (adv_count == AW'(ADVANCE_CYC - 1));
  wire           can_adv   = (mode != MODE_2X) && !low_done;

  // [R3] Shutdown or camera enable falling returns the pump to 1x
  assign reset_to_1x = low_done || cam_fall;

  // [R2] Delay counted from first dropout seen; advance aborted by a reset to 1x
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adv_pending <= 1'b0;
      adv_count   <= '0;
    end else if (reset_to_1x || adv_done) begin
      adv_pending <= 1'b0;
      adv_count   <= '0;
    end else if (adv_pending) begin
      adv_count   <= adv_count + AW'(1);
    end else if (any_drop && can_adv) begin
      adv_pending <= 1'b1;
    end
  end

  // [R1] Step 1x to 1.5x to 2x; [R11] 2x holds until a reset to 1x
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode <= MODE_1X;
    end else if (reset_to_1x) begin
      mode <= MODE_1X;
    end else if (adv_done) begin
      unique case (mode)
        MODE_1X:   mode <= MODE_1P5X;
        MODE_1P5X: mode <= MODE_2X;
        MODE_2X:   mode <= MODE_2X;
        default:   mode <= MODE_1X;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start ramp
  logic [RW-1:0] ramp_count;
  wire           boost_entry = adv_done && (mode != MODE_2X);
  wire [RAMP_W-1:0] ramp_calc =
    RAMP_W'((32'(ramp_count) * 32'(RAMP_FULL)) / 32'(RAMP_CYC));

  // [R5] Restarts at zero on each boost entry, rises linearly to full scale
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ramp_count <= '0;
    end else if (boost_entry || mode == MODE_1X) begin
      ramp_count <= '0;
    end else if (ramp_count != RW'(RAMP_CYC)) begin
      ramp_count <= ramp_count + RW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  logic phase_a;
  logic phase_b;
  wire  pump_run  = (mode != MODE_1X) && !low_done && !hot;

  // [R9] Non-overlapping phases only while boosting
  pump_phase_gen u_phase (
    .clock   (clock),
    .rst     (rst),
    .run     (pump_run),
    .phase_a (phase_a),
    .phase_b (phase_b)
  );

  // [R4] 1x pass switches close only once output is at or below supply
  wire next_main_sw = (mode == MODE_1X) && out_le_sup && !low_done && !hot;
  // [R8] Thermal fault holds sources off until the flag clears
  wire next_src_on  = !low_done && !hot;

  // [R7] Shutdown leaves only the weak switch; [R10] low enable zeroes output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drive          <= '{phase_a: 1'b0, phase_b: 1'b0, main_switch: 1'b0,
                          weak_switch: 1'b1, sources_on: 1'b0, mode: MODE_1X};
      ramp_level     <= '0;
      main_output_on <= 1'b0;
      cam_output_on  <= 1'b0;
      shutdown       <= 1'b1;
    end else begin
      drive.phase_a     <= phase_a;
      drive.phase_b     <= phase_b;
      drive.main_switch <= next_main_sw;
      drive.weak_switch <= low_done;
      drive.sources_on  <= next_src_on;
      drive.mode        <= mode;
      ramp_level        <= pump_run ? ramp_calc : '0;
      main_output_on    <= main_en && next_src_on;
      cam_output_on     <= cam_en && next_src_on;
      shutdown          <= low_done;
    end
  end

endmodule // charge_pump_mode_control
`default_nettype wire

// ==== hw/pump_ctrl_pkg.sv ====
// Package: constants and types for the charge pump mode supervisor
package pump_ctrl_pkg;

  // Clock rate and derived figures
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 5000;

  // Mode advance delay, 0.4 ms, counted in cycles (exact at 200 MHz, no rounding)
  localparam int ADVANCE_DELAY_US = 400;
  localparam int ADVANCE_DELAY_CYC = ADVANCE_DELAY_US * CLK_MHZ;

  // Soft-start ramp, 150 us
  localparam int SOFT_START_US = 150;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;

  // Both enables low for 150 us before shutdown
  localparam int SHUTDOWN_US = 150;
  localparam int SHUTDOWN_CYC = SHUTDOWN_US * CLK_MHZ;

  // Pump clock: 800 kHz period in ns, 35 ns non-overlap gap
  localparam int PUMP_PERIOD_NS = 1250;
  localparam int PUMP_GAP_NS = 35;
  localparam int PUMP_PERIOD_CYC = PUMP_PERIOD_NS * CLK_MHZ / 1000;
  localparam int PUMP_HALF_CYC = PUMP_PERIOD_CYC / 2;
  localparam int PUMP_GAP_CYC = (PUMP_GAP_NS * CLK_MHZ + 999) / 1000;

  // Soft-start level width and full-scale value
  localparam int RAMP_W = 8;
  localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;

  // Number of LED current sources watched for dropout
  localparam int NUM_SOURCES = 5;

  // Pump operating modes
  typedef enum logic [1:0] {
    MODE_1X,
    MODE_1P5X,
    MODE_2X
  } pump_mode_t;

  // Analog status inputs grouped together
  typedef struct packed {
    logic [NUM_SOURCES-1:0] dropout;
    logic                   out_le_supply;
    logic                   overtemp;
  } analog_status_t;

  // Controls to the analog pump
  typedef struct packed {
    logic       phase_a;
    logic       phase_b;
    logic       main_switch;
    logic       weak_switch;
    logic       sources_on;
    pump_mode_t mode;
  } pump_drive_t;

endpackage : pump_ctrl_pkg

// ==== hw/pump_phase_gen.sv ====
// Two-phase non-overlapping clock generator for the pump switches
`timescale 1ns/1ps
`default_nettype none
module pump_phase_gen
  import pump_ctrl_pkg::*;
#(
  parameter int PERIOD_CYC = PUMP_PERIOD_CYC,
  parameter int HALF_CYC   = PUMP_HALF_CYC,
  parameter int GAP_CYC    = PUMP_GAP_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      phase_a,
  output logic      phase_b
);

  localparam int CW = $clog2(PERIOD_CYC);

  logic [CW-1:0] count;
  wire           wrap      = (count == CW'(PERIOD_CYC - 1));
  wire           next_a    = run && (count < CW'(HALF_CYC - GAP_CYC));
  wire           next_b    = run && (count >= CW'(HALF_CYC))
                           && (count < CW'(PERIOD_CYC - GAP_CYC));

  // Free-running phase counter; held at zero while stopped so both phases stay low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run || wrap) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  // Registered phases; the gap at each half keeps the switches from overlapping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
    end else begin
      phase_a <= next_a;
      phase_b <= next_b;
    end
  end

endmodule // pump_phase_gen
`default_nettype wire

// ==== verification/pump_monitor.sv ====
// Checker on the charge pump supervisor ports, bound at the end of the file
`timescale 1ns/1ps
`default_nettype none
module pump_monitor
  import pump_ctrl_pkg::*;
#(
  parameter int ADVANCE_CYC    = 40,
  parameter int RAMP_CYC       = 20,
  parameter int SHUTDOWN_CYC_P = 30
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              main_enable_strobe,
  input wire logic              cam_enable_strobe,
  input wire analog_status_t    status,
  input wire pump_drive_t       drive,
  input wire logic [RAMP_W-1:0] ramp_level,
  input wire logic              main_output_on,
  input wire logic              shutdown
);
  localparam int R_LO = RAMP_CYC - 4;
  localparam int R_HI = RAMP_CYC + 6;
  logic [7:0] low_cnt;
  logic [7:0] drop_cnt;
  pump_mode_t prev_mode;
  wire        step_up = (drive.mode != prev_mode) && (drive.mode != MODE_1X);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Run lengths of both pins low and of any dropout; saturating so they never wrap.
  // The previous mode is kept here so a boost step can be seen outside a property.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt   <= 8'h00;
      drop_cnt  <= 8'h00;
      prev_mode <= MODE_1X;
    end else begin
      low_cnt   <= (main_enable_strobe || cam_enable_strobe) ? 8'h00
                 : low_cnt + 8'(low_cnt != 8'hFF);
      drop_cnt  <= (|status.dropout) ? drop_cnt + 8'(drop_cnt != 8'hFF) : 8'h00;
      prev_mode <= drive.mode;
    end
  end
  a_shut_late: assert property (low_cnt == 8'(SHUTDOWN_CYC_P + 10) |-> shutdown)
    else $error("no shutdown after long low enables");
  a_shut_early: assert property ($rose(shutdown) |-> low_cnt >= 8'(SHUTDOWN_CYC_P))
    else $error("shutdown came too early");
  a_shut_one_x: assert property (shutdown [*3] |-> drive.mode == MODE_1X)
    else $error("mode not 1x in shutdown");
  a_shut_quiet: assert property (shutdown [*3] |-> drive.weak_switch && !drive.main_switch
    && !drive.sources_on && !drive.phase_a)
    else $error("circuitry active in shutdown");
  a_phase_gap: assert property ($fell(drive.phase_a) |-> !drive.phase_b [*6])
    else $error("phase gap too short");
  a_hot_off: assert property (status.overtemp [*7] |-> !drive.sources_on && !drive.phase_a
    && !drive.phase_b)
    else $error("sources or pump on while hot");
  a_main_wait: assert property (!status.out_le_supply [*6] |-> !drive.main_switch)
    else $error("main switch closed above supply");
  a_mode_step: assert property ($changed(drive.mode) |-> drive.mode == MODE_1X
    || drive.mode == pump_mode_t'($past(drive.mode) + 2'h1))
    else $error("illegal mode step");
  a_two_x_stay: assert property ($changed(drive.mode) && $past(drive.mode) == MODE_2X
    |-> drive.mode == MODE_1X)
    else $error("2x left for a boost mode");
  a_adv_delay: assert property (step_up |-> drop_cnt >= 8'(ADVANCE_CYC))
    else $error("mode advanced too soon");
  a_ramp_full: assert property (step_up |-> ##[R_LO:R_HI] ramp_level == RAMP_FULL)
    else $error("soft-start ramp off time");
  a_off_main: assert property (!main_enable_strobe [*6] |-> !main_output_on)
    else $error("main output on with enable low");
  c_two_x: cover property (step_up && drive.mode == MODE_2X);
  c_shut: cover property ($rose(shutdown));
  c_hot: cover property (status.overtemp && drive.sources_on);
endmodule // pump_monitor

bind charge_pump_mode_control pump_monitor #(.ADVANCE_CYC(ADVANCE_CYC), .RAMP_CYC(RAMP_CYC),
  .SHUTDOWN_CYC_P(SHUTDOWN_CYC_P)) pump_monitor_i (.clock(clock), .rst(rst),
  .main_enable_strobe(main_enable_strobe), .cam_enable_strobe(cam_enable_strobe),
  .status(status), .drive(drive), .ramp_level(ramp_level),
  .main_output_on(main_output_on), .shutdown(shutdown));
`default_nettype wire

// ==== verification/host_pins_model.sv ====
// Host and analog side model: the two enable pins and the status lines
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
  import pump_ctrl_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           want_main,
  input  wire logic           want_cam,
  input  wire analog_status_t want_status,
  output var logic            main_enable_strobe,
  output var logic            cam_enable_strobe,
  output var analog_status_t  status
);
  initial begin
    main_enable_strobe = 1'b0;
    cam_enable_strobe  = 1'b0;
    status             = 7'h02;
  end
  // host holds a pin low to turn it off; pins move on the falling edge only
  always @(negedge clock) begin
    main_enable_strobe <= want_main;
    cam_enable_strobe  <= want_cam;
    status             <= want_status;
  end
endmodule // host_pins_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the charge pump mode supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pump_ctrl_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              want_main = 1'b0;
  logic              want_cam = 1'b0;
  analog_status_t    want_status = 7'h02;
  wire logic         main_enable_strobe;
  wire logic         cam_enable_strobe;
  wire analog_status_t status;
  pump_drive_t       drive;
  logic [RAMP_W-1:0] ramp_level;
  logic              main_output_on;
  logic              cam_output_on;
  logic              shutdown;
  int                n_errors = 0;
  int                check_count = 0;
  always #2.5 clock = ~clock;
  host_pins_model host_pins_model_i (.clock(clock), .want_main(want_main),
    .want_cam(want_cam), .want_status(want_status), .main_enable_strobe(main_enable_strobe),
    .cam_enable_strobe(cam_enable_strobe), .status(status));
  // Short counts keep the run brief; expectations below follow these values
  charge_pump_mode_control #(.ADVANCE_CYC(40), .RAMP_CYC(20), .SHUTDOWN_CYC_P(30))
    charge_pump_mode_control_i (.clock(clock), .rst(rst),
    .main_enable_strobe(main_enable_strobe), .cam_enable_strobe(cam_enable_strobe),
    .status(status), .drive(drive), .ramp_level(ramp_level),
    .main_output_on(main_output_on), .cam_output_on(cam_output_on), .shutdown(shutdown));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Start-up state, then both outputs enabled
  task automatic t_reset;
    chk(8'({shutdown, drive.weak_switch, drive.mode}), 8'h0C, "start state");
    want_main <= 1'b1;
    want_cam  <= 1'b1;
    wait_cyc(10);
    chk(8'({shutdown, main_output_on, cam_output_on}), 8'h03, "enable");
    $display("reset test done");
  endtask
  // Dropout walks 1x, 1.5x, 2x and 2x stays put
  task automatic t_advance;
    int na;
    int nb;
    na = 0;
    nb = 0;
    want_status.dropout <= 5'h01;
    wait_cyc(35);
    chk(8'(drive.mode), 8'(MODE_1X), "early advance");
    wait_cyc(20);
    chk(8'(drive.mode), 8'(MODE_1P5X), "to 1.5x");
    wait_cyc(20);
    chk(8'(drive.mode), 8'(MODE_1P5X), "early 2x");
    chk(ramp_level, RAMP_FULL, "ramp");
    wait_cyc(25);
    chk(8'(drive.mode), 8'(MODE_2X), "to 2x");
    wait_cyc(60);
    chk(8'(drive.mode), 8'(MODE_2X), "2x left");
    repeat (250) begin
      @(negedge clock);
      na += int'(drive.phase_a);
      nb += int'(drive.phase_b);
    end
    chk(8'(na > 100 && na < 125 && nb > 100 && nb < 125), 8'h01, "phases");
    want_status.dropout <= 5'h00;
    $display("advance test done");
  endtask
  // Overtemperature stops pump and sources, cooling restores the sources
  task automatic t_hot;
    want_status.overtemp <= 1'b1;
    wait_cyc(10);
    chk(8'({drive.sources_on, drive.phase_a, drive.phase_b}), 8'h00, "hot");
    want_status.overtemp <= 1'b0;
    wait_cyc(10);
    chk(8'(drive.sources_on), 8'h01, "cooled");
    $display("thermal test done");
  endtask
  // Camera enable fall returns 1x; switches wait for the comparator
  task automatic t_cam_fall;
    want_status.out_le_supply <= 1'b0;
    want_cam <= 1'b0;
    wait_cyc(10);
    chk(8'(drive.mode), 8'(MODE_1X), "cam fall");
    chk(8'(drive.main_switch), 8'h00, "switch early");
    want_status.out_le_supply <= 1'b1;
    wait_cyc(10);
    chk(8'(drive.main_switch), 8'h01, "switch");
    $display("camera test done");
  endtask
  // Both enables low: shutdown only after the hold time
  task automatic t_shutdown;
    want_main <= 1'b0;
    wait_cyc(25);
    chk(8'(shutdown), 8'h00, "early shutdown");
    wait_cyc(20);
    chk(8'(shutdown), 8'h01, "shutdown");
    chk(8'({drive.weak_switch, drive.sources_on, drive.mode}), 8'h08, "off");
    $display("shutdown test done");
  endtask
  initial begin
    wait_cyc(6);
    rst <= 1'b0;
    wait_cyc(2);
    t_reset();
    t_advance();
    t_hot();
    t_cam_fall();
    t_shutdown();
    close_out();
  end
  // Whole run is about 510 cycles; this leaves ample slack
  initial begin
    #20000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // testbench
`default_nettype wire
